// File: src/io_space_pkg.sv
// package: address map, field masks, reset values and carriers of the i/o register decoder
package io_space_pkg;

	// address arithmetic between i/o numbering and data-space numbering
	localparam logic [7:0] IO_TO_DATA_OFFSET = 8'h20;
	localparam logic [7:0] BIT_OP_IO_LIMIT = 8'h20;
	localparam logic [7:0] IO_OP_LIMIT = 8'h40;
	localparam logic [7:0] DATA_IO_FIRST = 8'h20;
	localparam logic [7:0] EXT_IO_FIRST = 8'h60;
	localparam logic [7:0] EXT_IO_LAST = 8'hFF;

	// data-space addresses of the extended registers
	localparam logic [7:0] ADDR_PIN_CHANGE_IRQ_CONTROL = 8'h68;
	localparam logic [7:0] ADDR_EXTERNAL_IRQ_SENSE_CONTROL = 8'h69;
	localparam logic [7:0] ADDR_PIN_CHANGE_MASK_LOW = 8'h6B;
	localparam logic [7:0] ADDR_PIN_CHANGE_MASK_HIGH = 8'h6C;
	localparam logic [7:0] ADDR_COUNTER0_IRQ_MASK = 8'h6E;
	localparam logic [7:0] ADDR_COUNTER1_IRQ_MASK = 8'h6F;
	localparam logic [7:0] ADDR_ANALOG_PIN_DIGITAL_INPUT_OFF = 8'h7E;
	localparam logic [7:0] ADDR_COUNTER1_MODE_CONTROL = 8'h80;
	localparam logic [7:0] ADDR_COUNTER1_CLOCK_SELECT = 8'h81;
	localparam logic [7:0] ADDR_COUNTER1_CAPTURE_SOURCE = 8'h82;
	localparam logic [7:0] ADDR_COUNTER1_VALUE_LOW = 8'h84;
	localparam logic [7:0] ADDR_COUNTER1_VALUE_HIGH = 8'h85;
	localparam logic [7:0] ADDR_COUNTER1_COMPARE_A = 8'h88;
	localparam logic [7:0] ADDR_COUNTER1_COMPARE_B = 8'h89;

	// data-space addresses of the low i/o registers kept here
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h3C;
	localparam logic [7:0] ADDR_SCRATCH_LOW = 8'h3E;
	localparam logic [7:0] ADDR_SCRATCH_MID = 8'h4A;

	// implemented bit positions; everything else is reserved
	localparam logic [7:0] MASK_PIN_CHANGE_IRQ_CONTROL = 8'h03;
	localparam logic [7:0] MASK_EXTERNAL_IRQ_SENSE_CONTROL = 8'h03;
	localparam logic [7:0] MASK_PIN_CHANGE_MASK_LOW = 8'h03;
	localparam logic [7:0] MASK_PIN_CHANGE_MASK_HIGH = 8'hFF;
	localparam logic [7:0] MASK_COUNTER_IRQ_MASK = 8'h0F;
	localparam logic [7:0] MASK_ANALOG_PIN_DIGITAL_INPUT_OFF = 8'h03;
	localparam logic [7:0] MASK_COUNTER1_MODE_CONTROL = 8'hF1;
	localparam logic [7:0] MASK_COUNTER1_CLOCK_SELECT = 8'h07;
	localparam logic [7:0] MASK_COUNTER1_CAPTURE_SOURCE = 8'h03;
	localparam logic [7:0] MASK_FULL_BYTE = 8'hFF;

	localparam logic [7:0] RESET_REG_VALUE = 8'h00;

	typedef enum logic [2:0] {
		io_read_op,
		io_write_op,
		set_single_bit_op,
		clear_single_bit_op,
		skip_if_bit_set_op,
		skip_if_bit_clear_op,
		memory_load_op,
		memory_save_op
	} access_op_e;

	typedef struct packed {
		logic valid;
		access_op_e op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_sel;
	} core_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic skip;
		logic error;
	} core_rsp_s;

	typedef struct packed {
		logic [7:0] pin_change_irq_control;
		logic [7:0] external_irq_sense_control;
		logic [7:0] pin_change_mask_low;
		logic [7:0] pin_change_mask_high;
		logic [7:0] counter0_irq_mask;
		logic [7:0] counter1_irq_mask;
		logic [7:0] analog_pin_digital_input_off;
		logic [7:0] counter1_mode_control;
		logic [7:0] counter1_clock_select;
		logic [7:0] counter1_capture_source;
		logic [7:0] counter1_value_low;
		logic [7:0] counter1_value_high;
		logic [7:0] counter1_compare_a;
		logic [7:0] counter1_compare_b;
		logic [7:0] event_flags;
		logic [7:0] scratch_low;
		logic [7:0] scratch_mid;
	} reg_bank_s;

endpackage

// File: src/io_register_space_decoder.sv
// i/o register space decoder: access classes, address mapping and the register bank
//
// How it works
// - only i/o addresses 0x00-0x1F accept single-bit set, clear and skip tests
// - writing one clears a status flag; writing zero leaves it alone
// - single-bit set/clear rewrite the whole register, so set flags get cleared, except the flag that a clear targets
// - dedicated i/o read/write reach only i/o addresses 0x00-0x3F
// - i/o address plus 0x20 gives the data-space address
// - extended range 0x60-0xFF is reached only by memory load and save
`timescale 1ns/1ps

module io_register_space_decoder
	import io_space_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire core_req_s req,
	input wire logic [7:0] event_flag_set,
	output core_rsp_s rsp,
	output reg_bank_s regs
);

	typedef struct packed {
		core_rsp_s rsp;
		reg_bank_s regs;
	} state_s;

	state_s q;
	state_s next_q;

	// read a data-space address; reserved bits and addresses give zero
	function automatic logic [7:0] reg_read(input reg_bank_s b, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_PIN_CHANGE_IRQ_CONTROL: v = b.pin_change_irq_control & MASK_PIN_CHANGE_IRQ_CONTROL;
			ADDR_EXTERNAL_IRQ_SENSE_CONTROL: v = b.external_irq_sense_control & MASK_EXTERNAL_IRQ_SENSE_CONTROL;
			ADDR_PIN_CHANGE_MASK_LOW: v = b.pin_change_mask_low & MASK_PIN_CHANGE_MASK_LOW;
			ADDR_PIN_CHANGE_MASK_HIGH: v = b.pin_change_mask_high & MASK_PIN_CHANGE_MASK_HIGH;
			ADDR_COUNTER0_IRQ_MASK: v = b.counter0_irq_mask & MASK_COUNTER_IRQ_MASK;
			ADDR_COUNTER1_IRQ_MASK: v = b.counter1_irq_mask & MASK_COUNTER_IRQ_MASK;
			ADDR_ANALOG_PIN_DIGITAL_INPUT_OFF: v = b.analog_pin_digital_input_off & MASK_ANALOG_PIN_DIGITAL_INPUT_OFF;
			ADDR_COUNTER1_MODE_CONTROL: v = b.counter1_mode_control & MASK_COUNTER1_MODE_CONTROL;
			ADDR_COUNTER1_CLOCK_SELECT: v = b.counter1_clock_select & MASK_COUNTER1_CLOCK_SELECT;
			ADDR_COUNTER1_CAPTURE_SOURCE: v = b.counter1_capture_source & MASK_COUNTER1_CAPTURE_SOURCE;
			ADDR_COUNTER1_VALUE_LOW: v = b.counter1_value_low;
			ADDR_COUNTER1_VALUE_HIGH: v = b.counter1_value_high;
			ADDR_COUNTER1_COMPARE_A: v = b.counter1_compare_a;
			ADDR_COUNTER1_COMPARE_B: v = b.counter1_compare_b;
			ADDR_EVENT_FLAGS: v = b.event_flags;
			ADDR_SCRATCH_LOW: v = b.scratch_low;
			ADDR_SCRATCH_MID: v = b.scratch_mid;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// write a whole byte; only implemented bits are stored
	function automatic reg_bank_s reg_write(input reg_bank_s b, input logic [7:0] a, input logic [7:0] v);
		reg_bank_s n;
		n = b;
		case (a)
			ADDR_PIN_CHANGE_IRQ_CONTROL: n.pin_change_irq_control = v & MASK_PIN_CHANGE_IRQ_CONTROL;
			ADDR_EXTERNAL_IRQ_SENSE_CONTROL: n.external_irq_sense_control = v & MASK_EXTERNAL_IRQ_SENSE_CONTROL;
			ADDR_PIN_CHANGE_MASK_LOW: n.pin_change_mask_low = v & MASK_PIN_CHANGE_MASK_LOW;
			ADDR_PIN_CHANGE_MASK_HIGH: n.pin_change_mask_high = v & MASK_PIN_CHANGE_MASK_HIGH;
			ADDR_COUNTER0_IRQ_MASK: n.counter0_irq_mask = v & MASK_COUNTER_IRQ_MASK;
			ADDR_COUNTER1_IRQ_MASK: n.counter1_irq_mask = v & MASK_COUNTER_IRQ_MASK;
			ADDR_ANALOG_PIN_DIGITAL_INPUT_OFF: n.analog_pin_digital_input_off = v & MASK_ANALOG_PIN_DIGITAL_INPUT_OFF;
			ADDR_COUNTER1_MODE_CONTROL: n.counter1_mode_control = v & MASK_COUNTER1_MODE_CONTROL;
			ADDR_COUNTER1_CLOCK_SELECT: n.counter1_clock_select = v & MASK_COUNTER1_CLOCK_SELECT;
			ADDR_COUNTER1_CAPTURE_SOURCE: n.counter1_capture_source = v & MASK_COUNTER1_CAPTURE_SOURCE;
			ADDR_COUNTER1_VALUE_LOW: n.counter1_value_low = v & MASK_FULL_BYTE;
			ADDR_COUNTER1_VALUE_HIGH: n.counter1_value_high = v & MASK_FULL_BYTE;
			ADDR_COUNTER1_COMPARE_A: n.counter1_compare_a = v & MASK_FULL_BYTE;
			ADDR_COUNTER1_COMPARE_B: n.counter1_compare_b = v & MASK_FULL_BYTE;
			ADDR_EVENT_FLAGS: n.event_flags = b.event_flags & ~v;
			ADDR_SCRATCH_LOW: n.scratch_low = v;
			ADDR_SCRATCH_MID: n.scratch_mid = v;
			default: n = b;
		endcase
		return n;
	endfunction

	// decode the access class, then do the access in the same cycle
	always_comb
	begin
		logic legal;
		logic [7:0] daddr;
		logic [7:0] cur;
		logic [7:0] bit_mask;
		legal = 1'b0;
		daddr = 8'h00;
		cur = 8'h00;
		bit_mask = 8'h01 << req.bit_sel;
		next_q = q;
		next_q.rsp = '0;
		if (req.valid)
		begin
			case (req.op)
				io_read_op, io_write_op:
				begin
					legal = req.addr < IO_OP_LIMIT;
					daddr = req.addr + IO_TO_DATA_OFFSET;
				end
				set_single_bit_op, clear_single_bit_op, skip_if_bit_set_op, skip_if_bit_clear_op:
				begin
					legal = req.addr < BIT_OP_IO_LIMIT;
					daddr = req.addr + IO_TO_DATA_OFFSET;
				end
				memory_load_op, memory_save_op:
				begin
					// whole 0x20..0xFF, so the extended range is open here only
					legal = req.addr >= DATA_IO_FIRST;
					daddr = req.addr;
				end
				default:
				begin
					legal = 1'b0;
					daddr = 8'h00;
				end
			endcase
			cur = reg_read(q.regs, daddr);
			next_q.rsp.valid = 1'b1;
			next_q.rsp.error = ~legal;
			if (legal)
			begin
				case (req.op)
					io_read_op, memory_load_op:
						next_q.rsp.rdata = cur;
					io_write_op, memory_save_op:
						next_q.regs = reg_write(q.regs, daddr, req.wdata);
					// whole byte written back: any set flag sees a one and clears
					set_single_bit_op:
						next_q.regs = reg_write(q.regs, daddr, cur | bit_mask);
					clear_single_bit_op:
						next_q.regs = reg_write(q.regs, daddr, cur & ~bit_mask);
					skip_if_bit_set_op:
					begin
						next_q.rsp.rdata = cur;
						next_q.rsp.skip = |(cur & bit_mask);
					end
					skip_if_bit_clear_op:
					begin
						next_q.rsp.rdata = cur;
						next_q.rsp.skip = ~|(cur & bit_mask);
					end
					default:
						next_q.rsp.rdata = 8'h00;
				endcase
			end
		end
		// events applied last so a set in the clear cycle wins
		next_q.regs.event_flags = next_q.regs.event_flags | event_flag_set;
	end

	// state register; all registers clear to their reset value
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			q.rsp <= '0;
			q.regs <= {17{RESET_REG_VALUE}};
		end
		else
		begin
			q <= next_q;
		end
	end

	assign rsp = q.rsp;
	assign regs = q.regs;

endmodule // io_register_space_decoder

// File: sim/io_register_space_decoder_asserts.sv
// checker: answer timing, access classes and flag rules
`timescale 1ns/1ps
module io_decoder_checker
	import io_space_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire core_req_s req,
	input wire logic [7:0] event_flag_set,
	input wire core_rsp_s rsp,
	input wire reg_bank_s regs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// bit ops above the bit range, and a bit set on the flags with no event pending
	sequence bit_far;
		req.valid && req.op inside {[set_single_bit_op:skip_if_bit_clear_op]} && req.addr >= BIT_OP_IO_LIMIT;
	endsequence
	sequence flag_set_op;
		req.valid && req.op == set_single_bit_op && req.addr == 8'h1C && event_flag_set == 8'h00;
	endsequence
	answer_follows_a: assert property (req.valid |=> rsp.valid) else $error("no answer");
	bit_range_a: assert property (bit_far |=> rsp.error) else $error("bit op not refused");
	flag_flush_a: assert property (flag_set_op |=> regs.event_flags == 8'h00) else $error("flags kept");
	w1c_write_a: assert property (req.valid && req.op == io_write_op && req.addr == 8'h1C
		&& event_flag_set == 8'h00 |=> regs.event_flags == ($past(regs.event_flags) & ~$past(req.wdata)))
		else $error("w1c wrong");
	// an event pulse must survive a clear taken in the same cycle
	set_wins_a: assert property (event_flag_set != 8'h00
		|=> (regs.event_flags & $past(event_flag_set)) == $past(event_flag_set)) else $error("event lost");
	io_range_a: assert property (req.valid && req.op inside {io_read_op, io_write_op} && req.addr >= IO_OP_LIMIT
		|=> rsp.error) else $error("io op not refused");
	ext_mem_a: assert property (req.valid && req.op inside {memory_load_op, memory_save_op}
		&& req.addr >= EXT_IO_FIRST |=> !rsp.error) else $error("ext refused");
	// loads and saves below the i/o window would hit the core register file
	mem_low_a: assert property (req.valid && req.op inside {memory_load_op, memory_save_op}
		&& req.addr < DATA_IO_FIRST |=> rsp.error) else $error("core file reached");
	io_map_a: assert property (req.valid && req.op == io_write_op && req.addr == 8'h1E
		|=> regs.scratch_low == $past(req.wdata)) else $error("io map wrong");
	reserved_read_a: assert property (req.valid && req.op == memory_load_op && req.addr == 8'h6A
		|=> rsp.valid && rsp.rdata == 8'h00 && !rsp.error) else $error("reserved read");
	error_quiet_a: assert property (rsp.error |-> rsp.rdata == 8'h00) else $error("data on error");
endmodule // io_decoder_checker

bind io_register_space_decoder io_decoder_checker i_chk (.mclk, .srst, .req, .event_flag_set, .rsp, .regs);

// File: sim/core_model.sv
// behavioural core issuing one access at a time
`timescale 1ns/1ps
module core_model
	import io_space_pkg::*;
(
	input wire logic mclk,
	input wire core_rsp_s rsp,
	output core_req_s req
);
	initial req = '0;
	// request held to the taking edge; on release valid drops, op stays, address, data and bit go inverted
	task automatic access(input access_op_e op, input logic [7:0] a, w, input logic [2:0] b, output core_rsp_s r);
		@(posedge mclk);
		req <= '{1'b1, op, a, w, b};
		@(posedge mclk);
		req <= '{1'b0, op, ~a, ~w, ~b};
		#1 r = rsp;
	endtask
endmodule // core_model

// File: sim/test_io_register_space_decoder.sv
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ps
module test_io_register_space_decoder
	import io_space_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] event_flag_set = 8'h00;
	core_req_s req;
	core_rsp_s rsp;
	core_rsp_s r;
	reg_bank_s regs;
	int mismatches = 0;
	int num_checks = 0;
	logic [7:0] ext_a [14] = '{8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6E, 8'h6F, 8'h7E, 8'h80, 8'h81, 8'h82, 8'h84, 8'h85,
		8'h88, 8'h89};
	logic [7:0] ext_m [14] = '{8'h03, 8'h03, 8'h03, 8'hFF, 8'h0F, 8'h0F, 8'h03, 8'hF1, 8'h07, 8'h03, 8'hFF, 8'hFF,
		8'hFF, 8'hFF};
	always #4 mclk = ~mclk;
	io_register_space_decoder i_dut (.mclk, .srst, .req, .event_flag_set, .rsp, .regs);
	core_model i_core (.mclk, .rsp, .req);
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic acc(input access_op_e op, input logic [7:0] a, w = 8'h00, input logic [2:0] b = 3'h0);
		i_core.access(op, a, w, b, r);
	endtask
	task automatic results;
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// every register clears on reset
	task automatic t_reset;
		#1;
		for (int i = 0; i < 17; i++)
			chk8(regs[i*8 +: 8], 8'h00);
	endtask
	// same register by i/o and data numbering; bit ops on low range only
	task automatic t_map;
		acc(io_write_op, 8'h1E, 8'hA5);
		acc(memory_load_op, 8'h3E);
		chk8(r.rdata, 8'hA5);
		chk1(r.valid, 1'b1);
		acc(memory_load_op, 8'h10);
		chk1(r.error, 1'b1);
		acc(memory_save_op, 8'h4A, 8'h3C);
		acc(io_read_op, 8'h2A);
		chk8(r.rdata, 8'h3C);
		acc(io_read_op, 8'h40);
		chk1(r.error, 1'b1);
		acc(set_single_bit_op, 8'h1E, 8'h00, 3'h6);
		acc(io_read_op, 8'h1E);
		chk8(r.rdata, 8'hE5);
		acc(clear_single_bit_op, 8'h2A, 8'h00, 3'h2);
		chk1(r.error, 1'b1);
	endtask
	// extended range by loads and saves only; reserved bits and places read zero
	task automatic t_ext;
		for (int i = 0; i < 14; i++)
		begin
			acc(memory_save_op, ext_a[i], 8'hFF);
			acc(io_write_op, ext_a[i] - 8'h20, 8'h00);
			chk1(r.error, 1'b1);
			acc(memory_load_op, ext_a[i]);
			chk8(r.rdata, ext_m[i]);
		end
		// reserved places are only read: software never writes them
		acc(memory_load_op, 8'h6A);
		chk1(r.error, 1'b0);
		chk8(r.rdata, 8'h00);
	endtask
	// event flags: skip tests, write-one-to-clear, bit set flushing all flags
	task automatic t_flags;
		@(posedge mclk);
		event_flag_set <= 8'h05;
		@(posedge mclk);
		event_flag_set <= 8'h00;
		acc(skip_if_bit_set_op, 8'h1C, 8'h00, 3'h2);
		chk1(r.skip, 1'b1);
		acc(skip_if_bit_clear_op, 8'h1C, 8'h00, 3'h1);
		chk1(r.skip, 1'b1);
		acc(skip_if_bit_set_op, 8'h1C, 8'h00, 3'h1);
		chk1(r.skip, 1'b0);
		acc(io_write_op, 8'h1C, 8'h01);
		acc(io_write_op, 8'h1C, 8'h00);
		acc(io_read_op, 8'h1C);
		chk8(r.rdata, 8'h04);
		acc(set_single_bit_op, 8'h1C, 8'h00, 3'h1);
		acc(io_read_op, 8'h1C);
		chk8(r.rdata, 8'h00);
		// event and clear taken at one edge: the event must win
		fork
			acc(io_write_op, 8'h1C, 8'h01);
			begin
				@(posedge mclk);
				event_flag_set <= 8'h01;
				@(posedge mclk);
				event_flag_set <= 8'h00;
			end
		join
		acc(memory_load_op, 8'h3C);
		chk8(r.rdata, 8'h01);
	endtask
	// a reset in mid-run clears written registers and the answer
	task automatic t_rerun;
		acc(memory_save_op, 8'h89, 8'h5A);
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		#1;
		for (int i = 0; i < 17; i++)
			chk8(regs[i*8 +: 8], 8'h00);
		chk1(rsp.valid, 1'b0);
		acc(memory_load_op, 8'h89);
		chk8(r.rdata, 8'h00);
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		t_reset;
		t_map;
		t_ext;
		t_flags;
		t_rerun;
		results;
	end
	// about 150 cycles of work; a hang ends here
	initial
	begin
		repeat (2000) @(posedge mclk);
		mismatches++;
		results;
	end
endmodule // test_io_register_space_decoder
